/* design/wcs_pkg.sv */
// weld ramp sequencer constants and types
package wcs_pkg;
    // line-cycle timing
    localparam int unsigned CLK_FREQ_HZ = 250000000;
    localparam int unsigned LINE_FREQ_HZ = 60;
    localparam int unsigned LINE_CYCLE_CLKS = CLK_FREQ_HZ / LINE_FREQ_HZ;
    localparam int LINE_CNT_W = 23;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SCHED_BASE = 8'h40;
    localparam logic [7:0] ADDR_SCHED_LAST = 8'h5C;
    localparam int SCHED_AW = 3;
    localparam int SCHED_N = 8;
    // schedule word fields
    localparam int SCH_HEAT_LSB = 0;
    localparam int SCH_WELD_LSB = 8;
    localparam int SCH_RLEN_LSB = 16;
    localparam int SCH_RSEL_LSB = 24;
    localparam int SCH_VALVE_LSB = 26;
    localparam int SCH_LINK_BIT = 29;
    // control word fields
    localparam int CTRL_PROG_BIT = 0;
    localparam int CTRL_INIT_BIT = 1;
    localparam int CTRL_SEAM_BIT = 2;
    localparam int CTRL_SEL_LSB = 3;
    localparam int CTRL_IMP_LSB = 8;
    // status word fields
    localparam int STAT_LVL_LSB = 8;
    localparam int STAT_VALVE_LSB = 16;
    localparam int STAT_WELD_BIT = 19;
    localparam int STAT_IMP_LSB = 24;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
    localparam logic [31:0] SCHED_RESET = 32'h0000_0000;
    // ramp selections and limits
    localparam logic [1:0] RSEL_NONE = 2'h0;
    localparam logic [1:0] RSEL_UP = 2'h1;
    localparam logic [1:0] RSEL_DOWN = 2'h2;
    localparam logic [6:0] RAMP_LEN_MIN = 7'h01;
    localparam logic [6:0] RAMP_LEN_MAX = 7'h63;
    localparam int HEAT_QUARTER_SHIFT = 2;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH_A, ST_FETCH_B, ST_SETUP, ST_RAMP_UP,
        ST_WELD, ST_COOL, ST_RAMP_DOWN, ST_FINISH
    } wcs_state_e;
endpackage

/* design/wcs_sched_mem.sv */
// schedule table: byte-writable, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module wcs_sched_mem
    import wcs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // write port
    input wire logic we_i,
    input wire logic [SCHED_AW-1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    // sequencer read port
    input wire logic [SCHED_AW-1:0] raddr_a_i,
    output logic [31:0] rdata_a_o,
    // bus read port
    input wire logic [SCHED_AW-1:0] raddr_b_i,
    output logic [31:0] rdata_b_o
);
    logic [31:0] mem_reg [SCHED_N];

    genvar gi;
    generate
        for (gi = 0; gi < SCHED_N; gi++) begin : g_word
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    mem_reg[gi] <= SCHED_RESET;
                end else if (we_i && waddr_i == SCHED_AW'(gi)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wstrb_i[b]) begin
                            mem_reg[gi][b*8 +: 8] <= wdata_i[b*8 +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        rdata_a_o <= mem_reg[raddr_a_i];
        rdata_b_o <= mem_reg[raddr_b_i];
    end
endmodule
`default_nettype wire

/* design/wcs_line_tick.sv */
// line-cycle divider: one-cycle enable per mains cycle
`timescale 1ns/10ps
`default_nettype none
module wcs_line_tick
    import wcs_pkg::*;
#(
    parameter int unsigned DIV = LINE_CYCLE_CLKS
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // enable out
    output logic tick_o
);
    logic [LINE_CNT_W-1:0] cnt_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (cnt_reg == LINE_CNT_W'(DIV - 1)) begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* design/wcs_weld_ramp.sv */
// weld ramp sequencer, valve decoder, axi4-lite registers
// Operation
// - ramp length limited to 01..99
// - ramp up rises, ramp down falls stepwise
// - ramp cycles added to weld cycles
// - ramp lengths and weld count independent
// - select 00 welds flat, no ramp
// - select 01 ramps up before weld
// - repeat: ramp up before first impulse only
// - seam: ramp up on first initiation only
// - own start is quarter heat, even steps
// - linked up: own heat to next heat
// - select 02 ramps down after weld
// - repeat: ramp down after last impulse
// - seam: ramp down when initiation released
// - own down: heat to quarter heat
// - linked down: bottom is next heat
// - valve code bits drive valves 1..3
// - programming: lamps show code, valves off
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module wcs_weld_ramp
    import wcs_pkg::*;
#(
    parameter int unsigned LINE_CLKS = LINE_CYCLE_CLKS
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // firing stage and valve drivers
    output logic [6:0] fire_level_o,
    output logic weld_on_o,
    output logic [2:0] valve_o,
    output logic [2:0] valve_lamp_o
);
    function automatic logic [31:0] merge_strb(input logic [31:0] old_w, input logic [31:0] new_w,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [6:0] clamp_len(input logic [6:0] len);
        if (len < RAMP_LEN_MIN) begin
            return RAMP_LEN_MIN;
        end else if (len > RAMP_LEN_MAX) begin
            return RAMP_LEN_MAX;
        end
        return len;
    endfunction

    function automatic logic is_sched(input logic [7:0] addr);
        return addr >= ADDR_SCHED_BASE && addr <= ADDR_SCHED_LAST;
    endfunction

    logic line_tick;
    logic [31:0] ctrl_reg;
    logic [31:0] rd_a, rd_b;
    logic aw_held_reg, w_held_reg, ar_stage_reg;
    logic [7:0] aw_addr_reg, ar_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    logic [31:0] sched_wdata;
    wcs_state_e state_reg;
    logic [31:0] sched_a_reg;
    logic [6:0] lvl_reg, weld_lvl_reg, end_lvl_reg, inc_reg, rlen_reg, weld_reg, cnt_reg;
    logic [1:0] rsel_reg;
    logic [2:0] valve_reg;
    logic [7:0] imp_cnt_reg;
    logic init_q_reg;

    wire prog_mode = ctrl_reg[CTRL_PROG_BIT];
    wire init_lvl = ctrl_reg[CTRL_INIT_BIT];
    wire seam_mode = ctrl_reg[CTRL_SEAM_BIT];
    wire [SCHED_AW-1:0] sel = ctrl_reg[CTRL_SEL_LSB +: SCHED_AW];
    wire [7:0] impulses = ctrl_reg[CTRL_IMP_LSB +: 8];

    wcs_line_tick #(
        .DIV(LINE_CLKS)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tick_o(line_tick)
    );

    // clamp on write so readers see legal lengths
    always_comb begin
        sched_wdata = w_data_reg;
        sched_wdata[SCH_RLEN_LSB +: 7] = clamp_len(w_data_reg[SCH_RLEN_LSB +: 7]);
    end

    wire fetching = state_reg == ST_FETCH_A || state_reg == ST_FETCH_B;

    wcs_sched_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .we_i(do_write && is_sched(aw_addr_reg)),
        .waddr_i(aw_addr_reg[2 +: SCHED_AW]),
        .wdata_i(sched_wdata),
        .wstrb_i(w_strb_reg),
        .raddr_a_i(fetching ? sel + 1'b1 : sel),
        .rdata_a_o(rd_a),
        .raddr_b_i(s_axi_araddr[2 +: SCHED_AW]),
        .rdata_b_o(rd_b)
    );

    // write: address and data in either order
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg == ADDR_CTRL || is_sched(aw_addr_reg)) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (do_write && aw_addr_reg == ADDR_CTRL) begin
            ctrl_reg <= merge_strb(ctrl_reg, w_data_reg, w_strb_reg);
        end
    end

    // read: table addressed at handshake, answer two cycles on
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b1;
            ar_addr_reg <= 8'h00;
            ar_stage_reg <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            ar_stage_reg <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_addr_reg <= s_axi_araddr;
                s_axi_arready <= 1'b0;
                ar_stage_reg <= 1'b1;
            end
            if (ar_stage_reg) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                if (ar_addr_reg == ADDR_CTRL) begin
                    s_axi_rdata <= ctrl_reg;
                end else if (ar_addr_reg == ADDR_STATUS) begin
                    s_axi_rdata <= {imp_cnt_reg, 4'h0, weld_on_o, valve_o, 1'b0, fire_level_o,
                                    4'h0, state_reg};
                end else if (is_sched(ar_addr_reg)) begin
                    s_axi_rdata <= rd_b;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ramp setup from schedule and linked successor
    wire [6:0] heat_a = sched_a_reg[SCH_HEAT_LSB +: 7];
    wire [6:0] heat_b = rd_a[SCH_HEAT_LSB +: 7];
    wire linked = sched_a_reg[SCH_LINK_BIT];
    wire [1:0] rsel_a = sched_a_reg[SCH_RSEL_LSB +: 2];
    logic [6:0] su_start, su_end, su_weld_lvl, su_weld, su_diff;

    always_comb begin
        su_weld = sched_a_reg[SCH_WELD_LSB +: 7];
        su_weld_lvl = heat_a;
        su_start = heat_a;
        su_end = heat_a;
        if (rsel_a == RSEL_UP) begin
            su_start = linked ? heat_a : heat_a >> HEAT_QUARTER_SHIFT;
            su_end = linked ? heat_b : heat_a;
            su_weld_lvl = su_end;
            su_weld = linked ? rd_a[SCH_WELD_LSB +: 7] : su_weld;
        end else if (rsel_a == RSEL_DOWN) begin
            su_end = linked ? heat_b : heat_a >> HEAT_QUARTER_SHIFT;
        end
        if (su_start > su_end) begin
            su_diff = su_start - su_end;
        end else begin
            su_diff = su_end - su_start;
        end
    end

    wire ramp_last = cnt_reg == rlen_reg - 1'b1;
    wire weld_last = cnt_reg + 1'b1 >= weld_reg;
    wire has_down = rsel_reg == RSEL_DOWN;

    // timed states step only on the line tick
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            init_q_reg <= 1'b0;
            sched_a_reg <= 32'h0000_0000;
            lvl_reg <= 7'h00;
            weld_lvl_reg <= 7'h00;
            end_lvl_reg <= 7'h00;
            inc_reg <= 7'h00;
            rlen_reg <= RAMP_LEN_MIN;
            weld_reg <= 7'h00;
            cnt_reg <= 7'h00;
            rsel_reg <= RSEL_NONE;
            valve_reg <= 3'h0;
            imp_cnt_reg <= 8'h00;
        end else begin
            init_q_reg <= init_lvl;
            if (prog_mode) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (init_lvl && !init_q_reg) begin
                            state_reg <= ST_FETCH_A;
                        end
                    end
                    ST_FETCH_A: begin
                        sched_a_reg <= rd_a;
                        state_reg <= ST_FETCH_B;
                    end
                    ST_FETCH_B: begin
                        state_reg <= ST_SETUP;
                    end
                    ST_SETUP: begin
                        rsel_reg <= rsel_a;
                        rlen_reg <= sched_a_reg[SCH_RLEN_LSB +: 7];
                        weld_reg <= su_weld;
                        weld_lvl_reg <= su_weld_lvl;
                        end_lvl_reg <= su_end;
                        inc_reg <= su_diff / sched_a_reg[SCH_RLEN_LSB +: 7];
                        valve_reg <= sched_a_reg[SCH_VALVE_LSB +: 3];
                        imp_cnt_reg <= 8'h00;
                        cnt_reg <= 7'h00;
                        if (rsel_a == RSEL_UP) begin
                            lvl_reg <= su_start;
                            state_reg <= ST_RAMP_UP;
                        end else begin
                            lvl_reg <= su_weld_lvl;
                            state_reg <= ST_WELD;
                        end
                    end
                    ST_RAMP_UP: begin
                        if (line_tick) begin
                            if (ramp_last) begin
                                cnt_reg <= 7'h00;
                                lvl_reg <= weld_lvl_reg;
                                state_reg <= ST_WELD;
                            end else begin
                                cnt_reg <= cnt_reg + 1'b1;
                                lvl_reg <= lvl_reg + inc_reg;
                            end
                        end
                    end
                    ST_WELD: begin
                        if (line_tick && weld_last) begin
                            cnt_reg <= 7'h00;
                            if (seam_mode && init_lvl) begin
                                lvl_reg <= weld_lvl_reg;
                            end else if (!seam_mode && imp_cnt_reg + 1'b1 < impulses) begin
                                imp_cnt_reg <= imp_cnt_reg + 1'b1;
                                state_reg <= ST_COOL;
                            end else if (has_down) begin
                                lvl_reg <= rlen_reg == RAMP_LEN_MIN ? end_lvl_reg : lvl_reg - inc_reg;
                                state_reg <= ST_RAMP_DOWN;
                            end else begin
                                state_reg <= ST_FINISH;
                            end
                        end else if (line_tick) begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                    ST_COOL: begin
                        if (line_tick) begin
                            lvl_reg <= weld_lvl_reg;
                            state_reg <= ST_WELD;
                        end
                    end
                    ST_RAMP_DOWN: begin
                        if (line_tick) begin
                            if (ramp_last) begin
                                state_reg <= ST_FINISH;
                            end else begin
                                cnt_reg <= cnt_reg + 1'b1;
                                lvl_reg <= cnt_reg + 7'h02 == rlen_reg ? end_lvl_reg : lvl_reg - inc_reg;
                            end
                        end
                    end
                    ST_FINISH: begin
                        if (!init_lvl) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    wire firing = state_reg == ST_RAMP_UP || state_reg == ST_WELD || state_reg == ST_RAMP_DOWN;
    wire running = state_reg != ST_IDLE && !fetching && state_reg != ST_SETUP;

    // program mode forces valves and firing off
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            fire_level_o <= 7'h00;
            weld_on_o <= 1'b0;
            valve_o <= 3'h0;
            valve_lamp_o <= 3'h0;
        end else begin
            fire_level_o <= (firing && !prog_mode) ? lvl_reg : 7'h00;
            weld_on_o <= firing && !prog_mode;
            valve_o <= (running && !prog_mode) ? valve_reg : 3'h0;
            if (prog_mode) begin
                valve_lamp_o <= rd_a[SCH_VALVE_LSB +: 3];
            end else begin
                valve_lamp_o <= running ? valve_reg : 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/wcs_checker.sv */
// port assertions for the weld ramp sequencer
`timescale 1ns/10ps
`default_nettype none
module wcs_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // firing stage
    input wire logic [6:0] fire_level_o,
    input wire logic weld_on_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_fire_idle;
        !weld_on_o |-> fire_level_o == 7'h00;
    endproperty
    a_fire_idle: assert property (p_fire_idle) else $error("idle level");
    // a step lasts a line cycle; eight clocks is a floor
    property p_level_hold;
        weld_on_o && $past(weld_on_o) && $changed(fire_level_o) |=> $stable(fire_level_o)[*8];
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("early step");
    property p_aw_drop;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_drop: assert property (p_aw_drop) else $error("awready held");
    property p_ar_drop;
        s_axi_arvalid && s_axi_arready |=> !s_axi_arready;
    endproperty
    a_ar_drop: assert property (p_ar_drop) else $error("arready held");
    property p_r_soon;
        s_axi_arvalid && s_axi_arready |-> ##[2:4] s_axi_rvalid;
    endproperty
    a_r_soon: assert property (p_r_soon) else $error("late read");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("rvalid held");
    property p_ar_rel;
        s_axi_rvalid && s_axi_rready |=> s_axi_arready;
    endproperty
    a_ar_rel: assert property (p_ar_rel) else $error("arready low");
    property p_b_rel;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
    endproperty
    a_b_rel: assert property (p_b_rel) else $error("b not freed");
endmodule
bind wcs_weld_ramp wcs_checker u_wcs_checker (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fire_level_o(fire_level_o), .weld_on_o(weld_on_o)
);
`default_nettype wire

/* bench/wcs_fire_model.sv */
// firing stage and valve driver stand-in
`timescale 1ns/10ps
`default_nettype none
module wcs_fire_model (
    input wire logic ref_clk_i,
    input wire logic [6:0] fire_level_i,
    input wire logic weld_on_i,
    input wire logic [2:0] valve_i
);
    logic [6:0] lvl_q[$];
    logic [6:0] prev = 7'h00;
    logic [2:0] valve_seen = 3'h0;
    int on_cyc = 0;
    // logs changes only; tests keep neighbours distinct
    always @(posedge ref_clk_i) begin
        if (fire_level_i !== prev) lvl_q.push_back(fire_level_i);
        prev <= fire_level_i;
        if (weld_on_i) begin
            on_cyc++;
            valve_seen <= valve_i;
        end
    end
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the weld ramp sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
    import wcs_pkg::*;
    localparam int L = 20;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'h0;
    logic awr, wrd, bv, arr, rv, on;
    logic [1:0] br, rr, r;
    logic [31:0] rd_d, q;
    logic [6:0] lvl;
    logic [2:0] vo, vl;
    int mismatches = 0, compares = 0;
    integer seed = 32'hC419;
    int exp_q[$];
    always #2 ref_clk_i = ~ref_clk_i;
    wcs_weld_ramp #(.LINE_CLKS(L)) u_wcs_weld_ramp (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd_d), .s_axi_rresp(rr),
        .fire_level_o(lvl), .weld_on_o(on), .valve_o(vo), .valve_lamp_o(vl)
    );
    wcs_fire_model u_wcs_fire_model (.ref_clk_i(ref_clk_i), .fire_level_i(lvl), .weld_on_i(on), .valve_i(vo));
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic hang();
        mismatches++;
        $display("[ERR] wait exp done got timeout");
        results();
    endtask
    task automatic xfer(bit w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
        bit ah, wh, rh, gh;
        @(posedge ref_clk_i);
        if (w) begin
            awv <= 1'b1;
            wv <= 1'b1;
            awa <= a;
            wd <= d;
            ws <= s;
            bry <= 1'b1;
        end else begin
            arv <= 1'b1;
            ara <= a;
            rry <= 1'b1;
        end
        // sampled mid-cycle, once settled
        for (int n = 0; n < 100; n++) begin
            @(negedge ref_clk_i);
            ah = awv && awr;
            wh = wv && wrd;
            rh = arv && arr;
            gh = w ? bv : rv;
            q = rd_d;
            r = w ? br : rr;
            @(posedge ref_clk_i);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
            if (rh) arv <= 1'b0;
            if (gh) begin
                bry <= 1'b0;
                rry <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        xfer(1, a, d, 4'hF);
    endtask
    task automatic rd(logic [7:0] a);
        xfer(0, a, 0, 0);
    endtask
    task automatic poll(logic [3:0] t);
        for (int n = 0; n < 2000; n++) begin
            rd(ADDR_STATUS);
            if (q[3:0] === t) return;
        end
        hang();
    endtask
    task automatic run(string nm, logic [31:0] c, int hold, logic [2:0] code, int ticks, int s, int t, int b, int n,
                       int sel, int imp);
        exp_q = {};
        for (int i = 0; i < n && sel == 1; i++) exp_q.push_back(s + i * ((t - s) / n));
        for (int k = 0; k < imp; k++) begin
            exp_q.push_back(t);
            if (k < imp - 1) exp_q.push_back(0);
        end
        for (int i = 1; i <= n && sel == 2; i++) exp_q.push_back(i == n ? b : t - i * ((t - b) / n));
        exp_q.push_back(0);
        @(negedge ref_clk_i);
        u_wcs_fire_model.lvl_q.delete();
        u_wcs_fire_model.on_cyc = 0;
        wr(ADDR_CTRL, c | 32'h2);
        repeat (hold) @(posedge ref_clk_i);
        if (!c[CTRL_SEAM_BIT]) poll(4'h8);
        wr(ADDR_CTRL, c);
        poll(4'h0);
        chk({nm, "_n"}, u_wcs_fire_model.lvl_q.size(), exp_q.size());
        foreach (exp_q[i]) chk(nm, u_wcs_fire_model.lvl_q[i], exp_q[i]);
        chk({nm, "_valve"}, u_wcs_fire_model.valve_seen, code);
        if (ticks > 0) chk({nm, "_ticks"}, (u_wcs_fire_model.on_cyc + L - 1) / L, ticks);
        $display("test %s done", nm);
    endtask
    initial begin
        logic [31:0] w;
        int h, wc, n, sel;
        logic [2:0] code;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CTRL);
        chk("ctrl_rst", q, CTRL_RESET);
        rd(ADDR_SCHED_LAST);
        chk("sched_rst", q, SCHED_RESET);
        rd(8'h10);
        chk("unmapped_rd", r, RESP_SLVERR);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        chk("status_wr", r, RESP_SLVERR);
        wr(ADDR_SCHED_BASE, 32'h0000_0500);
        rd(ADDR_SCHED_BASE);
        chk("rlen_lo", q[22:16], RAMP_LEN_MIN);
        xfer(1, ADDR_SCHED_BASE, 32'h0078_0000, 4'h4);
        rd(ADDR_SCHED_BASE);
        chk("rlen_hi", q[22:16], RAMP_LEN_MAX);
        chk("weld_kept", q[14:8], 7'h05);
        $display("test registers done");
        // random flat, up and down schedules
        for (int i = 0; i < 6; i++) begin
            sel = i % 3;
            h = 40 + {$random(seed)} % 60;
            wc = 1 + {$random(seed)} % 4;
            n = 1 + {$random(seed)} % 9;
            code = 3'($random(seed));
            w = (code << SCH_VALVE_LSB) | (sel << SCH_RSEL_LSB) | (n << SCH_RLEN_LSB) | (wc << SCH_WELD_LSB) | h;
            wr(ADDR_SCHED_BASE, w);
            run("single", 32'h100, 0, code, wc + (sel > 0 ? n : 0), h / 4, h, h / 4, n, sel, 1);
        end
        wr(ADDR_SCHED_BASE, 32'h250F_001E);
        wr(8'h44, 32'h0400_024B);
        run("link_up", 32'h100, 0, 3'h1, 17, 30, 75, 0, 15, 1, 1);
        wr(8'h48, 32'h260F_024B);
        wr(8'h4C, 32'h0400_000F);
        run("link_down", 32'h110, 0, 3'h1, 17, 0, 75, 15, 15, 2, 1);
        wr(8'h50, 32'h1504_0150);
        run("rep_up", 32'h320, 0, 3'h5, 0, 20, 80, 0, 4, 1, 3);
        wr(8'h50, 32'h1604_0150);
        run("rep_down", 32'h320, 0, 3'h5, 0, 0, 80, 20, 4, 2, 3);
        wr(8'h54, 32'h0D09_023C);
        run("seam_up", 32'h12C, 15 * L, 3'h3, 0, 15, 60, 0, 9, 1, 1);
        wr(8'h54, 32'h0E09_023C);
        run("seam_down", 32'h12C, 8 * L, 3'h3, 0, 0, 60, 15, 9, 2, 1);
        // program mode must drop a running weld's valves
        wr(8'h58, 32'h1800_0000);
        wr(ADDR_CTRL, 32'h0000_0132);
        poll(4'h8);
        chk("run_valve", vo, 3'h6);
        wr(ADDR_CTRL, 32'h0000_0133);
        repeat (4) @(negedge ref_clk_i);
        chk("prog_valve", vo, 3'h0);
        chk("prog_lamp", vl, 3'h6);
        wr(ADDR_CTRL, 32'h0000_0100);
        $display("test program done");
        results();
    end
endmodule
`default_nettype wire
